// *** hw/twmc_channel.sv ***
// One 16-bit timer channel in waveform mode with its APB register slave.
// Assumes all inputs are synchronous to core_clk and the APB master is well behaved.
//
// Functional notes
// [R1] Soft reset command clears every channel register; the edge history flops and prdata_reg keep their values.
// [R2] Clock on unless off set; off disables.
// [R3] Software trigger restarts counter at next edge.
// [R4] Source select: core divided or external clocks.
// [R5] Invert bit counts on falling edges.
// [R6] Burst field ANDs selected clock with gate.
// [R7] Halt bit stops counter at compare C.
// [R8] Stopped counter restarts from zero on trigger.
// [R9] Compare C stop beats its own trigger.
// [R10] Clock-off bit disables clock at compare C.
// [R11] Edge field picks none, rise, fall, both.
// [R12] Event sets flag, drives pins, may trigger.
// [R13] Source field picks pin B or external.
// [R14] Pin B source means single mode, input.
// [R15] External source means dual mode, outputs.
// [R16] Trigger enable lets events restart counter.
// [R17] Retrigger bit makes compare C a trigger.
// [R18] Four action fields drive pin A.
// [R19] Action codes: none, set, clear, toggle.
// [R20] Pin A priority: soft, event, C, A.
// [R21] Pin B alike with compare B.
// [R22] Waveform bit forces pin A output.
// [R23] Sixteen-bit counter, increments, trigger zeroes.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module twmc_channel
  import twmc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire twmc_apb_req_t apb_req,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [2:0]    external_clock_in,
  input  wire logic          waveform_pin_b_i,
  output logic               waveform_pin_a_o,
  output logic               waveform_pin_a_oe,
  output logic               waveform_pin_b_o,
  output logic               waveform_pin_b_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  twmc_mode_t                   mode_reg;
  logic [TWMC_CNT_W-1:0]        cmp_reg [3];
  logic [TWMC_CNT_W-1:0]        count_reg;
  logic [TWMC_PRESCALE_W-1:0]   prescale_reg;
  logic                         clk_on_reg;
  logic                         running_reg;
  logic                         pending_reg;
  logic                         updated_reg;
  logic                         trig_flag_reg;
  logic                         pin_a_reg;
  logic                         pin_b_reg;
  logic                         gclk_prev_reg;
  logic                         evt_prev_reg;
  logic [31:0]                  prdata_reg;

  logic        wr_access;
  logic        rd_access;
  logic        cmd_wr;
  logic        soft_rst;
  logic        sw_trg;
  logic        addr_hit;
  logic [31:0] read_value;
  logic        src_level;
  logic        burst_level;
  logic        gclk;
  logic        tick;
  logic        evt_level;
  logic        ext_event;
  logic        dual_mode;
  logic [2:0]  match;
  logic        stop_on_c;
  logic        cpc_trig;
  logic        any_trig;
  logic        status_rd;
  twmc_action_t act_a;
  twmc_action_t act_b;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_access = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  assign cmd_wr    = wr_access && (apb_req.paddr == TWMC_CMD_OFS);
  assign soft_rst  = cmd_wr && apb_req.pwdata[TWMC_CMD_RST_BIT]; // [R1]
  assign sw_trg    = cmd_wr && apb_req.pwdata[TWMC_CMD_TRG_BIT] && !soft_rst;
  assign status_rd = rd_access && (apb_req.paddr == TWMC_STATUS_OFS);

  always_comb begin
    addr_hit   = 1'b1;
    read_value = 32'h0000_0000;
    case (apb_req.paddr)
      TWMC_CMD_OFS:    read_value = 32'h0000_0000;
      TWMC_MODE_OFS:   read_value = mode_reg;
      TWMC_CMP_A_OFS:  read_value = {16'h0000, cmp_reg[0]};
      TWMC_CMP_B_OFS:  read_value = {16'h0000, cmp_reg[1]};
      TWMC_CMP_C_OFS:  read_value = {16'h0000, cmp_reg[2]};
      TWMC_STATUS_OFS: begin
        read_value[TWMC_ST_CNT_LSB +: TWMC_CNT_W] = count_reg;
        read_value[TWMC_ST_CLK_BIT]  = clk_on_reg;
        read_value[TWMC_ST_RUN_BIT]  = running_reg;
        read_value[TWMC_ST_FLAG_BIT] = trig_flag_reg;
        read_value[TWMC_ST_PINA_BIT] = pin_a_reg;
        read_value[TWMC_ST_PINB_BIT] = pin_b_reg;
      end
      default: addr_hit = 1'b0;
    endcase
  end

  // Read data is sampled in the setup cycle so it leaves a flip-flop in the access cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      prdata_reg <= read_value;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = apb_req.psel && apb_req.penable && !addr_hit;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= TWMC_MODE_RESET;
    end else if (soft_rst) begin
      mode_reg <= TWMC_MODE_RESET; // [R1]
    end else if (wr_access && apb_req.paddr == TWMC_MODE_OFS) begin
      mode_reg <= twmc_mode_t'(apb_req.pwdata & ~(32'h0000_0001 << TWMC_MODE_RSVD_BIT));
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cmp
      localparam logic [7:0] OFS = TWMC_CMP_A_OFS + 8'(4 * gi);
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cmp_reg[gi] <= TWMC_CMP_RESET;
        end else if (soft_rst) begin
          cmp_reg[gi] <= TWMC_CMP_RESET;
        end else if (wr_access && apb_req.paddr == OFS) begin
          cmp_reg[gi] <= apb_req.pwdata[TWMC_CNT_W-1:0];
        end
      end
      // A match is seen once, in the cycle after the counter took a new value.
      assign match[gi] = updated_reg && (count_reg == cmp_reg[gi]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Counter clock: prescaler, source select, inversion, burst gate
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_reg <= '0;
    end else if (soft_rst) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
    end
  end

  always_comb begin
    case (mode_reg.clock_source_select) // [R4]
      3'h0:    src_level = prescale_reg[TWMC_DIV2_TAP];
      3'h1:    src_level = prescale_reg[TWMC_DIV8_TAP];
      3'h2:    src_level = prescale_reg[TWMC_DIV32_TAP];
      3'h3:    src_level = prescale_reg[TWMC_DIV128_TAP];
      3'h4:    src_level = prescale_reg[TWMC_DIV1024_TAP];
      3'h5:    src_level = external_clock_in[0];
      3'h6:    src_level = external_clock_in[1];
      default: src_level = external_clock_in[2];
    endcase
    case (mode_reg.burst_select) // [R6]
      2'h0:    burst_level = 1'b1;
      2'h1:    burst_level = external_clock_in[0];
      2'h2:    burst_level = external_clock_in[1];
      default: burst_level = external_clock_in[2];
    endcase
  end

  // Inverting before the rising-edge detector makes falling edges count.
  assign gclk = (src_level ^ mode_reg.clock_edge_invert) & burst_level; // [R5] [R6]
  assign tick = gclk && !gclk_prev_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gclk_prev_reg <= 1'b0;
      evt_prev_reg  <= 1'b0;
    end else begin
      gclk_prev_reg <= gclk;
      evt_prev_reg  <= evt_level;
    end
  end

  // ----------------------------------------------------------------
  // External event detection
  // ----------------------------------------------------------------
  assign dual_mode = (mode_reg.event_source_select != 2'h0); // [R14] [R15]

  always_comb begin
    case (mode_reg.event_source_select) // [R13]
      2'h0:    evt_level = waveform_pin_b_i;
      2'h1:    evt_level = external_clock_in[0];
      2'h2:    evt_level = external_clock_in[1];
      default: evt_level = external_clock_in[2];
    endcase
    case (mode_reg.event_edge_select) // [R11]
      2'h0:    ext_event = 1'b0;
      2'h1:    ext_event = evt_level && !evt_prev_reg;
      2'h2:    ext_event = !evt_level && evt_prev_reg;
      default: ext_event = evt_level ^ evt_prev_reg;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_flag_reg <= 1'b0;
    end else if (soft_rst) begin
      trig_flag_reg <= 1'b0;
    end else begin
      // Only a flag the reader actually saw is cleared; a new event always wins.
      trig_flag_reg <= ext_event ||
                       (trig_flag_reg && !(status_rd && prdata_reg[TWMC_ST_FLAG_BIT])); // [R12]
    end
  end

  // ----------------------------------------------------------------
  // Triggers, clock enable and counter
  // ----------------------------------------------------------------
  assign stop_on_c = match[2] && (mode_reg.compare_c_halt || mode_reg.compare_c_clock_off);
  assign cpc_trig  = match[2] && mode_reg.compare_c_retrigger && !stop_on_c; // [R9] [R17]
  assign any_trig  = sw_trg || (ext_event && mode_reg.external_trigger_enable) || cpc_trig; // [R16]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_on_reg <= 1'b0;
    end else if (soft_rst) begin
      clk_on_reg <= 1'b0;
    end else if (cmd_wr && apb_req.pwdata[TWMC_CMD_OFF_BIT]) begin
      clk_on_reg <= 1'b0; // [R2]
    end else if (cmd_wr && apb_req.pwdata[TWMC_CMD_ON_BIT]) begin
      clk_on_reg <= 1'b1; // [R2]
    end else if (match[2] && mode_reg.compare_c_clock_off) begin
      clk_on_reg <= 1'b0; // [R10]
    end
  end

  // A trigger waits for the next counted edge; with the clock off it is dropped.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
    end else if (soft_rst || !clk_on_reg) begin
      pending_reg <= 1'b0;
    end else if (tick) begin
      pending_reg <= any_trig;
    end else if (any_trig) begin
      pending_reg <= 1'b1; // [R3]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg   <= TWMC_CNT_RESET;
      running_reg <= 1'b0;
      updated_reg <= 1'b0;
    end else if (soft_rst) begin
      count_reg   <= TWMC_CNT_RESET;
      running_reg <= 1'b0;
      updated_reg <= 1'b0;
    end else if (stop_on_c) begin
      running_reg <= 1'b0; // [R7] [R10]
      updated_reg <= 1'b0;
    end else if (tick && clk_on_reg && pending_reg) begin
      count_reg   <= TWMC_CNT_RESET; // [R8] [R23]
      running_reg <= 1'b1;
      updated_reg <= 1'b1;
    end else if (tick && clk_on_reg && running_reg) begin
      count_reg   <= count_reg + 1'b1; // [R23]
      updated_reg <= 1'b1;
    end else begin
      updated_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Waveform pins
  // ----------------------------------------------------------------
  // Events are ordered low to high priority; the last present one with an action wins.
  function automatic twmc_action_t pick_action(input logic [3:0] ev,
                                               input logic [7:0] codes);
    twmc_action_t res;
    res = TWMC_ACT_NONE;
    for (int i = 0; i < 4; i++) begin
      if (ev[i] && codes[2*i +: 2] != 2'h0) begin
        res = twmc_action_t'(codes[2*i +: 2]);
      end
    end
    return res;
  endfunction

  function automatic logic apply_action(input logic cur, input twmc_action_t act);
    case (act) // [R19]
      TWMC_ACT_SET:    return 1'b1;
      TWMC_ACT_CLEAR:  return 1'b0;
      TWMC_ACT_TOGGLE: return !cur;
      default:         return cur;
    endcase
  endfunction

  assign act_a = pick_action({sw_trg, ext_event, match[2], match[0]}, // [R18] [R20]
                             {mode_reg.pin_a_on_soft_trigger, mode_reg.pin_a_on_event,
                              mode_reg.pin_a_on_compare_c, mode_reg.pin_a_on_compare_a});
  assign act_b = pick_action({sw_trg, ext_event, match[2], match[1]}, // [R21]
                             {mode_reg.pin_b_on_soft_trigger, mode_reg.pin_b_on_event,
                              mode_reg.pin_b_on_compare_c, mode_reg.pin_b_on_compare_b});

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_reg <= 1'b0;
    end else if (soft_rst) begin
      pin_a_reg <= 1'b0;
    end else if (mode_reg.wave) begin
      pin_a_reg <= apply_action(pin_a_reg, act_a); // [R12]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_b_reg <= 1'b0;
    end else if (soft_rst) begin
      pin_b_reg <= 1'b0;
    end else if (mode_reg.wave && dual_mode) begin
      pin_b_reg <= apply_action(pin_b_reg, act_b); // [R14] [R21]
    end
  end

  assign waveform_pin_a_o  = pin_a_reg;
  assign waveform_pin_a_oe = mode_reg.wave; // [R22]
  assign waveform_pin_b_o  = pin_b_reg;
  assign waveform_pin_b_oe = mode_reg.wave && dual_mode; // [R14] [R15]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_off_cmd;
    cmd_wr && !soft_rst && apb_req.pwdata[TWMC_CMD_OFF_BIT];
  endsequence

  sequence s_restart;
    tick && clk_on_reg && pending_reg && !stop_on_c && !soft_rst;
  endsequence

  sequence s_c_halt;
    stop_on_c && !soft_rst;
  endsequence

  AST_CLK_OFF: assert property (s_off_cmd |=> !clk_on_reg) // [R2]
    else $error("clock stayed on after disable command");
  AST_CLK_ON: assert property (cmd_wr && !soft_rst && apb_req.pwdata[TWMC_CMD_ON_BIT]
      && !apb_req.pwdata[TWMC_CMD_OFF_BIT] |=> clk_on_reg) // [R2]
    else $error("clock not enabled by enable command");
  AST_SOFT_RST: assert property (soft_rst |=> count_reg == TWMC_CNT_RESET
      && mode_reg == TWMC_MODE_RESET && !clk_on_reg && !pin_a_reg) // [R1]
    else $error("channel not cleared by soft reset");
  AST_RESTART: assert property (s_restart |=> count_reg == TWMC_CNT_RESET
      && running_reg && updated_reg) // [R3]
    else $error("trigger did not restart counter from zero");
  AST_COUNT: assert property (tick && clk_on_reg && running_reg && !pending_reg
      && !stop_on_c && !soft_rst |=> count_reg == $past(count_reg) + 16'h0001) // [R23]
    else $error("counter did not advance by one");
  AST_HALT: assert property (s_c_halt |=> (!running_reg && !updated_reg)
      ##1 (running_reg || !updated_reg)) // [R7]
    else $error("counter kept running after compare C stop");
  AST_C_CLKOFF: assert property (s_c_halt ##0 mode_reg.compare_c_clock_off && !cmd_wr
      |=> !clk_on_reg) // [R10]
    else $error("compare C did not disable clock");
  AST_STOP_WINS: assert property (s_c_halt ##0 !sw_trg && !ext_event && !pending_reg
      |=> !pending_reg) // [R9]
    else $error("compare C trigger acted while stopping");
  AST_FLAG: assert property (ext_event && !soft_rst |=> trig_flag_reg) // [R12]
    else $error("event flag not set");
  AST_PIN_A_OE: assert property (!mode_reg.wave && !soft_rst
      |=> $stable(waveform_pin_a_o)) // [R22]
    else $error("pin A moved outside waveform mode");
  AST_PIN_B_DIR: assert property (!dual_mode && !soft_rst |=> $stable(pin_b_reg)) // [R14]
    else $error("pin B moved in single waveform operation");
  AST_SW_SET_A: assert property (sw_trg && mode_reg.wave
      && mode_reg.pin_a_on_soft_trigger == TWMC_ACT_SET |=> pin_a_reg) // [R20]
    else $error("software trigger action lost on pin A");

endmodule

// *** hw/twmc_pkg.sv ***
// Shared constants, register map and carrier types for the waveform timer channel.
// Assumes a single core clock and an APB master with 8 address bits in reach.
package twmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned TWMC_ADDR_W = 8;
  localparam logic [7:0] TWMC_CMD_OFS    = 8'h60;
  localparam logic [7:0] TWMC_MODE_OFS   = 8'h64;
  localparam logic [7:0] TWMC_CMP_A_OFS  = 8'h84;
  localparam logic [7:0] TWMC_CMP_B_OFS  = 8'h88;
  localparam logic [7:0] TWMC_CMP_C_OFS  = 8'h8C;
  localparam logic [7:0] TWMC_STATUS_OFS = 8'h90;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned TWMC_CMD_RST_BIT = 0;
  localparam int unsigned TWMC_CMD_ON_BIT  = 1;
  localparam int unsigned TWMC_CMD_OFF_BIT = 2;
  localparam int unsigned TWMC_CMD_TRG_BIT = 3;
  localparam int unsigned TWMC_MODE_RSVD_BIT = 13;
  localparam int unsigned TWMC_ST_CLK_BIT  = 0;
  localparam int unsigned TWMC_ST_RUN_BIT  = 1;
  localparam int unsigned TWMC_ST_FLAG_BIT = 2;
  localparam int unsigned TWMC_ST_PINA_BIT = 3;
  localparam int unsigned TWMC_ST_PINB_BIT = 4;
  localparam int unsigned TWMC_ST_CNT_LSB  = 16;
  localparam logic [31:0] TWMC_MODE_RESET = 32'h0000_0000;
  localparam logic [15:0] TWMC_CMP_RESET  = 16'h0000;
  localparam logic [15:0] TWMC_CNT_RESET  = 16'h0000;

  // ----------------------------------------------------------------
  // Counter width and prescaler taps (bit k of the prescaler divides by 2^(k+1))
  // ----------------------------------------------------------------
  localparam int unsigned TWMC_CNT_W      = 16;
  localparam int unsigned TWMC_PRESCALE_W = 10;
  localparam int unsigned TWMC_DIV2_TAP    = 0;
  localparam int unsigned TWMC_DIV8_TAP    = 2;
  localparam int unsigned TWMC_DIV32_TAP   = 4;
  localparam int unsigned TWMC_DIV128_TAP  = 6;
  localparam int unsigned TWMC_DIV1024_TAP = 9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TWMC_ACT_NONE,
    TWMC_ACT_SET,
    TWMC_ACT_CLEAR,
    TWMC_ACT_TOGGLE
  } twmc_action_t;

  typedef struct packed {
    twmc_action_t pin_b_on_soft_trigger;
    twmc_action_t pin_b_on_event;
    twmc_action_t pin_b_on_compare_c;
    twmc_action_t pin_b_on_compare_b;
    twmc_action_t pin_a_on_soft_trigger;
    twmc_action_t pin_a_on_event;
    twmc_action_t pin_a_on_compare_c;
    twmc_action_t pin_a_on_compare_a;
    logic         wave;
    logic         compare_c_retrigger;
    logic         reserved;
    logic         external_trigger_enable;
    logic [1:0]   event_source_select;
    logic [1:0]   event_edge_select;
    logic         compare_c_clock_off;
    logic         compare_c_halt;
    logic [1:0]   burst_select;
    logic         clock_edge_invert;
    logic [2:0]   clock_source_select;
  } twmc_mode_t;

  typedef struct packed {
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [TWMC_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata;
  } twmc_apb_req_t;

endpackage

// *** test/twmc_channel_tb.sv ***
// Self-checking bench for the waveform timer channel: registers, counter, pins.
// Assumes the channel answers APB within a few cycles and counts on core_clk.
`timescale 1ns/1ps
module twmc_channel_tb
  import twmc_pkg::*;
();
  logic          core_clk = 1'b0;
  logic          rst_n;
  twmc_apb_req_t apb_req;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [2:0]    external_clock_in;
  logic          waveform_pin_b_i;
  logic          pin_a;
  logic          pin_a_oe;
  logic          pin_b;
  logic          pin_b_oe;
  logic [31:0]   rd;
  logic          err;
  int            miscompares;
  int            checked;
  logic [31:0]   row_wr [5] = '{32'hFFFF_FFFF, 32'h0000_8000, 32'h0000_8400,
                                32'h0000_0C00, 32'hA5A5_5A5A};
  logic [31:0]   row_rd [5] = '{32'hFFFF_DFFF, 32'h0000_8000, 32'h0000_8400,
                                32'h0000_0C00, 32'hA5A5_5A5A};
  logic [1:0]    row_oe [5] = '{2'h3, 2'h2, 2'h3, 2'h0, 2'h0};

  twmc_channel dut (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .apb_req           (apb_req),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .external_clock_in (external_clock_in),
    .waveform_pin_b_i  (waveform_pin_b_i),
    .waveform_pin_a_o  (pin_a),
    .waveform_pin_a_oe (pin_a_oe),
    .waveform_pin_b_o  (pin_b),
    .waveform_pin_b_oe (pin_b_oe)
  );

  always #50 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The request stands until pready is seen high, then read data is taken.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= w;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      final_report();
    end
    rd  = prdata;
    err = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // Polls status until the counter has stopped at the given value.
  task automatic wait_cnt(input logic [15:0] c);
    int n;
    n = 0;
    do begin
      apb(1'b0, TWMC_STATUS_OFS, 32'h0);
      n++;
    end while ((rd[31:16] !== c || rd[TWMC_ST_RUN_BIT] !== 1'b0) && n < 60);
    if (rd[31:16] !== c || rd[TWMC_ST_RUN_BIT] !== 1'b0) begin
      miscompares++;
      final_report();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    apb_req           = '0;
    external_clock_in = 3'h0;
    waveform_pin_b_i  = 1'b0;
    rst_n             = 1'b0;
    miscompares       = 0;
    checked           = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, TWMC_MODE_OFS, 32'h0);
    chk("mode_reset", 32'h0, rd);
    apb(1'b0, TWMC_STATUS_OFS, 32'h0);
    chk("status_reset", 32'h0, rd);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, TWMC_MODE_OFS, row_wr[i]);
      apb(1'b0, TWMC_MODE_OFS, 32'h0);
      chk("mode_rb", row_rd[i], rd);
      chk("pin_oe", {30'h0, row_oe[i]}, {30'h0, pin_a_oe, pin_b_oe});
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    apb(1'b1, TWMC_CMD_OFS, 32'h1);
    apb(1'b0, TWMC_MODE_OFS, 32'h0);
    chk("soft_reset_mode", 32'h0, rd);
    apb(1'b1, TWMC_CMD_OFS, 32'h6);
    apb(1'b0, TWMC_STATUS_OFS, 32'h0);
    chk("clk_on_off", 32'h0, {31'h0, rd[TWMC_ST_CLK_BIT]});
    apb(1'b1, TWMC_CMD_OFS, 32'h2);
    apb(1'b0, TWMC_STATUS_OFS, 32'h0);
    chk("clk_on", 32'h1, {31'h0, rd[TWMC_ST_CLK_BIT]});
    // Halt at compare C; soft trigger sets pin A, compare C clears it.
    apb(1'b1, TWMC_CMP_C_OFS, 32'h5);
    apb(1'b1, TWMC_MODE_OFS, 32'h4048_8040);
    apb(1'b1, TWMC_CMD_OFS, 32'h8);
    @(negedge core_clk);
    chk("pin_a_sw", 32'h1, {31'h0, pin_a});
    wait_cnt(16'h5);
    chk("halt_status", 32'h0005_0001, rd);
    // A smaller compare value is only reached if the restart begins at zero.
    // The retrigger bit is set too: the stop must win over it.
    apb(1'b1, TWMC_CMP_C_OFS, 32'h3);
    apb(1'b1, TWMC_MODE_OFS, 32'h4048_C040);
    apb(1'b1, TWMC_CMD_OFS, 32'h8);
    wait_cnt(16'h3);
    chk("restart_status", 32'h0003_0001, rd);
    apb(1'b1, TWMC_CMP_C_OFS, 32'h4);
    apb(1'b1, TWMC_MODE_OFS, 32'h0048_8080);
    apb(1'b1, TWMC_CMD_OFS, 32'h8);
    wait_cnt(16'h4);
    chk("clk_off_status", 32'h0004_0000, rd);
    apb(1'b1, TWMC_CMD_OFS, 32'h8);
    apb(1'b0, TWMC_STATUS_OFS, 32'h0);
    chk("no_start_clk_off", 32'h0004_0000, rd & 32'hFFFF_0003);
    apb(1'b1, TWMC_CMD_OFS, 32'h2);
    apb(1'b0, TWMC_STATUS_OFS, 32'h0);
    chk("clk_reenable", 32'h1, {31'h0, rd[TWMC_ST_CLK_BIT]});
    // Rising event on external clock zero clears pin A and restarts the counter.
    apb(1'b1, TWMC_MODE_OFS, 32'h0020_9500);
    external_clock_in <= 3'h1;
    repeat (3) @(posedge core_clk);
    apb(1'b0, TWMC_STATUS_OFS, 32'h0);
    chk("event_flag", 32'h1, {31'h0, rd[TWMC_ST_FLAG_BIT]});
    chk("event_run", 32'h1, {31'h0, rd[TWMC_ST_RUN_BIT]});
    chk("event_pin_a", 32'h0, {31'h0, pin_a});
    apb(1'b0, TWMC_STATUS_OFS, 32'h0);
    chk("flag_cleared", 32'h0, {31'h0, rd[TWMC_ST_FLAG_BIT]});
    apb(1'b1, TWMC_MODE_OFS, 32'h4030_9600);
    external_clock_in <= 3'h0;
    repeat (3) @(posedge core_clk);
    chk("fall_pin_a", 32'h1, {31'h0, pin_a});
    chk("pin_b_idle", 32'h0, {31'h0, pin_b});
    apb(1'b1, TWMC_CMD_OFS, 32'h8);
    @(negedge core_clk);
    chk("pin_b_sw", 32'h1, {31'h0, pin_b});
    // Compare C retrigger keeps the counter cycling through 0 to 2.
    apb(1'b1, TWMC_CMP_C_OFS, 32'h2);
    apb(1'b1, TWMC_MODE_OFS, 32'h000C_C000);
    apb(1'b1, TWMC_CMD_OFS, 32'h8);
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, TWMC_STATUS_OFS, 32'h0);
      chk("retrig_cycle", 32'h1, {31'h0, rd[31:16] <= 16'h2 && rd[TWMC_ST_RUN_BIT]});
    end
    // External clock zero, inverted, gated by external clock one.
    apb(1'b1, TWMC_MODE_OFS, 32'h0000_002D);
    apb(1'b1, TWMC_CMD_OFS, 32'h8);
    external_clock_in <= 3'h2;
    repeat (2) @(posedge core_clk);
    external_clock_in <= 3'h3;
    repeat (2) @(posedge core_clk);
    apb(1'b0, TWMC_STATUS_OFS, 32'h0);
    chk("rise_no_count", 32'h0000_0003, rd & 32'hFFFF_0003);
    external_clock_in <= 3'h2;
    repeat (2) @(posedge core_clk);
    external_clock_in <= 3'h0;
    repeat (2) @(posedge core_clk);
    external_clock_in <= 3'h1;
    repeat (2) @(posedge core_clk);
    external_clock_in <= 3'h0;
    repeat (2) @(posedge core_clk);
    apb(1'b0, TWMC_STATUS_OFS, 32'h0);
    chk("gated_count", 32'h0001_0003, rd & 32'hFFFF_0003);
    final_report();
  end
endmodule
